/* core/pcg_clock_gen.sv */
// Functional notes
// - auto mode: tracking bit read-only, writes ignored
// - auto mode: tracking bit follows tracking tolerances
// - auto mode: lock bit follows lock tolerances
// - enabled interrupt on every lock toggle
// - manual mode: tracking bit is writable control
// - manual mode: lock disabled, no interrupts
// - upper program nibble is vco multiplier
// - lower program nibble is range multiplier
// - multiplier zero behaves as one
// - range zero disables pll, forces crystal
// - switch waits three edges each, output held
// - switched clock divided by two
// - no vco select while pll off
// - no pll off while vco selected
// - power and select change together only on a write that clears power and sets select
// - oscillator enable gates oscillator and pll
// - base clock is half of selected source
// - interrupt comes from lock detector logic
// - select bit picks crystal or vco path
// - select one vco, zero crystal
// - control register read clears lock-change flag
// - program register read-only while pll on
// - reset sets pll power-on bit
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_gen (
  input wire logic clk, // 250 MHz system clock
  input wire logic rst_n, // synchronous reset, low
  input wire pcg_pkg::pcg_bus_req_t bus_req, // register port request
  output logic [7:0] rdata, // read data, cycle after the read strobe
  input wire logic crystal_clock, // crystal oscillator clock, asynchronous
  input wire logic vco_clock, // vco clock, asynchronous
  input wire logic osc_enable_in, // oscillator enable from integration unit
  output logic base_clock_out, // half of the selected source
  output logic lock_change_irq, // interrupt request, high level
  output logic osc_run_en, // crystal oscillator enable
  output logic pll_run_en, // pll and vco enable
  output logic loop_track_mode, // loop filter in tracking mode
  output logic [3:0] vco_mult, // effective feedback multiplier
  output logic [3:0] vco_range // range multiplier to the vco
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detect

  logic [2:0] xs_q, vs_q;
  // the enable is a level, not an edge, so two flops are enough for it
  logic [1:0] es_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xs_q <= 3'h0;
      vs_q <= 3'h0;
      es_q <= 2'h0;
    end else begin
      xs_q <= {xs_q[1:0], crystal_clock};
      vs_q <= {vs_q[1:0], vco_clock};
      es_q <= {es_q[0], osc_enable_in};
    end
  end

  wire logic osc_en_s = es_q[1];
  // sampled sources must stay below half of clk; edges are seen late, not lost
  wire logic xtal_edge = osc_en_s && xs_q[1] && !xs_q[2];
  wire logic vco_edge_raw = vs_q[1] && !vs_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic ie_q, flag_q, pon_q, bcs_q, auto_q, man_trk_q, lock_prev_q;
  logic [7:0] prog_q;
  logic [7:0] rdata_q;

  wire logic [3:0] mul_field = prog_q[pcg_pkg::PROG_MUL_LSB +: 4];
  wire logic [3:0] rng_field = prog_q[pcg_pkg::PROG_RNG_LSB +: 4];
  wire logic [3:0] mul_eff = (mul_field == pcg_pkg::FIELD_ZERO) ?
      pcg_pkg::FIELD_ONE : mul_field;
  wire logic rng_zero = (rng_field == pcg_pkg::FIELD_ZERO);
  wire logic pll_active = pon_q && !rng_zero && osc_en_s;
  wire logic vco_edge = pll_active && vco_edge_raw;

  wire logic wr_ctrl = bus_req.wr && (bus_req.addr == pcg_pkg::ADDR_CTRL);
  wire logic wr_bw = bus_req.wr && (bus_req.addr == pcg_pkg::ADDR_BW);
  wire logic wr_prog = bus_req.wr && (bus_req.addr == pcg_pkg::ADDR_PROG);
  wire logic rd_ctrl = bus_req.rd && (bus_req.addr == pcg_pkg::ADDR_CTRL);

  wire logic w_pon = bus_req.wdata[pcg_pkg::CTRL_PON_BIT];
  wire logic w_bcs = bus_req.wdata[pcg_pkg::CTRL_BCS_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // lock detector

  logic det_lock, det_track;

  pcg_lock_det u_det (
    .clk(clk),
    .rst_n(rst_n),
    .enable(pll_active),
    .xtal_edge(xtal_edge),
    .vco_edge(vco_edge),
    .mult(mul_eff),
    .lock(det_lock),
    .track(det_track)
  );

  wire logic lock_vis = auto_q && det_lock;
  wire logic trk_vis = auto_q ? det_track : man_trk_q;
  wire logic lock_toggle = auto_q && (det_lock != lock_prev_q);

  ////////////////////////////////////////////////////////////////////////////
  // control and status updates

  // each write is judged against the bits as they stand, so a write that
  // tries to power up and select, or deselect and power down, loses the dependent change
  wire logic pon_d = (wr_ctrl && !bcs_q) ? w_pon : pon_q;
  wire logic bcs_set_ok = pon_q && !rng_zero;
  wire logic bcs_w = wr_ctrl ? (w_bcs && bcs_set_ok) : bcs_q;
  wire logic bcs_d = bcs_w && !rng_zero;
  wire logic ie_d = !auto_q ? 1'b0 :
      (wr_ctrl ? bus_req.wdata[pcg_pkg::CTRL_IE_BIT] : ie_q);
  // a toggle in the same cycle as the clearing read wins
  wire logic flag_d = !auto_q ? 1'b0 :
      (lock_toggle ? 1'b1 : (rd_ctrl ? 1'b0 : flag_q));
  wire logic man_trk_d = (wr_bw && !auto_q) ?
      bus_req.wdata[pcg_pkg::BW_TRK_BIT] : man_trk_q;
  wire logic [7:0] prog_d = (wr_prog && !pon_q) ? bus_req.wdata : prog_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ie_q <= 1'b0;
      flag_q <= 1'b0;
      pon_q <= pcg_pkg::CTRL_PON_RESET;
      bcs_q <= pcg_pkg::CTRL_BCS_RESET;
      auto_q <= 1'b0;
      man_trk_q <= 1'b0;
      lock_prev_q <= 1'b0;
      prog_q <= pcg_pkg::PROG_RESET;
    end else begin
      ie_q <= ie_d;
      flag_q <= flag_d;
      pon_q <= pon_d;
      bcs_q <= bcs_d;
      auto_q <= wr_bw ? bus_req.wdata[pcg_pkg::BW_AUTO_BIT] : auto_q;
      man_trk_q <= man_trk_d;
      lock_prev_q <= det_lock;
      prog_q <= prog_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  wire logic [7:0] ctrl_view = {ie_q && auto_q, flag_q && auto_q, pon_q, bcs_q,
      pcg_pkg::CTRL_LOW_READ};
  wire logic [7:0] bw_view = {auto_q, lock_vis, trk_vis, 5'h00};
  wire logic [7:0] rd_mux = (bus_req.addr == pcg_pkg::ADDR_CTRL) ? ctrl_view :
      (bus_req.addr == pcg_pkg::ADDR_BW) ? bw_view :
      (bus_req.addr == pcg_pkg::ADDR_PROG) ? prog_q : 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_n) rdata_q <= 8'h00;
    else rdata_q <= bus_req.rd ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transition controller and divider

  pcg_pkg::pcg_sw_state_t sw_q, sw_d;
  logic src_q, src_d, base_q, base_d;
  logic [1:0] xcnt_q, vcnt_q;

  wire logic xcnt_done = (xcnt_q == pcg_pkg::SWITCH_EDGES);
  // a stopped vco cannot deliver edges, so its count is waived then
  wire logic vcnt_done = (vcnt_q == pcg_pkg::SWITCH_EDGES) || !pll_active;
  wire logic src_edge = src_q ? vco_edge : xtal_edge;

  always_comb begin
    sw_d = sw_q;
    src_d = src_q;
    base_d = base_q;
    case (sw_q)
      pcg_pkg::SW_RUN: begin
        if (bcs_q != src_q) sw_d = pcg_pkg::SW_WAIT;
        else if (src_edge) base_d = !base_q;
      end
      pcg_pkg::SW_WAIT: begin
        if (xcnt_done && vcnt_done) begin
          src_d = bcs_q;
          sw_d = pcg_pkg::SW_RUN;
        end
      end
      default: sw_d = pcg_pkg::SW_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_q <= pcg_pkg::SW_RUN;
      src_q <= 1'b0;
      base_q <= 1'b0;
      xcnt_q <= 2'h0;
      vcnt_q <= 2'h0;
    end else begin
      sw_q <= sw_d;
      src_q <= src_d;
      base_q <= base_d;
      if (sw_q != pcg_pkg::SW_WAIT) begin
        xcnt_q <= 2'h0;
        vcnt_q <= 2'h0;
      end else begin
        if (xtal_edge && !xcnt_done) xcnt_q <= xcnt_q + 2'h1;
        if (vco_edge && vcnt_q != pcg_pkg::SWITCH_EDGES) vcnt_q <= vcnt_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic irq_q, osc_q, pll_q, trk_q;
  logic [3:0] mul_q, rng_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      osc_q <= 1'b0;
      pll_q <= 1'b0;
      trk_q <= 1'b0;
      mul_q <= 4'h0;
      rng_q <= 4'h0;
    end else begin
      irq_q <= auto_q && ie_q && flag_q;
      osc_q <= osc_en_s;
      pll_q <= pll_active;
      trk_q <= trk_vis;
      mul_q <= mul_eff;
      rng_q <= rng_field;
    end
  end

  assign rdata = rdata_q;
  assign base_clock_out = base_q;
  assign lock_change_irq = irq_q;
  assign osc_run_en = osc_q;
  assign pll_run_en = pll_q;
  assign loop_track_mode = trk_q;
  assign vco_mult = mul_q;
  assign vco_range = rng_q;

endmodule : pcg_clock_gen
`default_nettype wire

/* common/pcg_pkg.sv */
package pcg_pkg;

  // register indices on the plain register port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_BW = 2'h1;
  localparam logic [1:0] ADDR_PROG = 2'h2;

  // pll_control_reg fields
  localparam int CTRL_IE_BIT = 7;
  localparam int CTRL_FLAG_BIT = 6;
  localparam int CTRL_PON_BIT = 5;
  localparam int CTRL_BCS_BIT = 4;
  localparam logic [3:0] CTRL_LOW_READ = 4'hf;

  // bandwidth register fields
  localparam int BW_AUTO_BIT = 7;
  localparam int BW_LOCK_BIT = 6;
  localparam int BW_TRK_BIT = 5;

  // vco_multiplier_program fields and reset
  localparam int PROG_MUL_LSB = 4;
  localparam int PROG_RNG_LSB = 0;
  localparam logic [7:0] PROG_RESET = 8'h66;
  localparam logic [3:0] FIELD_ZERO = 4'h0;
  localparam logic [3:0] FIELD_ONE = 4'h1;

  // control reset values
  localparam logic CTRL_PON_RESET = 1'b1;
  localparam logic CTRL_BCS_RESET = 1'b0;

  // source edges waited for during a clock switch
  localparam logic [1:0] SWITCH_EDGES = 2'h3;

  // lock detector defaults
  localparam int DET_REF_WINDOW = 16;
  localparam int DET_LOCK_TOL = 2;
  localparam int DET_UNLOCK_TOL = 4;
  localparam int DET_TRACK_TOL = 4;
  localparam int DET_UNTRACK_TOL = 8;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pcg_bus_req_t;

  typedef enum logic [1:0] {
    SW_RUN = 2'b01,
    SW_WAIT = 2'b10
  } pcg_sw_state_t;

endpackage : pcg_pkg

/* core/pcg_lock_det.sv */
`timescale 1ns/1ps
`default_nettype none
module pcg_lock_det #(
  parameter int REF_WINDOW = pcg_pkg::DET_REF_WINDOW,
  parameter int LOCK_TOL = pcg_pkg::DET_LOCK_TOL,
  parameter int UNLOCK_TOL = pcg_pkg::DET_UNLOCK_TOL,
  parameter int TRACK_TOL = pcg_pkg::DET_TRACK_TOL,
  parameter int UNTRACK_TOL = pcg_pkg::DET_UNTRACK_TOL
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, low
  input wire logic enable, // pll running
  input wire logic xtal_edge, // crystal rising edge, one cycle
  input wire logic vco_edge, // vco rising edge, one cycle
  input wire logic [3:0] mult, // effective multiplier, never zero
  output logic lock, // frequency within lock band
  output logic track // frequency within tracking band
);

  localparam int CW = 12;

  generate
    if (REF_WINDOW < 2 || REF_WINDOW * 15 >= (1 << CW) - 1) begin : g_bad_win
      $error("pcg_lock_det: REF_WINDOW out of range");
    end
    if (LOCK_TOL > UNLOCK_TOL || TRACK_TOL > UNTRACK_TOL) begin : g_bad_tol
      $error("pcg_lock_det: acquire tolerance wider than release tolerance");
    end
  endgenerate

  logic [CW-1:0] win_q, win_d;
  logic [CW-1:0] vcnt_q, vcnt_d;
  logic lock_q, lock_d, track_q, track_d;

  // compare vco edges against multiplier times crystal edges in one window
  wire logic [CW-1:0] expected = CW'(mult) * CW'(REF_WINDOW);
  wire logic win_end = xtal_edge && (win_q == CW'(REF_WINDOW - 1));
  wire logic [CW-1:0] vcnt_now = vcnt_q + CW'(vco_edge);
  wire logic [CW-1:0] diff = (vcnt_now > expected) ? vcnt_now - expected : expected - vcnt_now;

  always_comb begin
    win_d = win_q;
    vcnt_d = vcnt_q;
    lock_d = lock_q;
    track_d = track_q;
    if (!enable) begin
      win_d = '0;
      vcnt_d = '0;
      lock_d = 1'b0;
      track_d = 1'b0;
    end else if (win_end) begin
      win_d = '0;
      vcnt_d = '0;
      // hysteresis: enter inside the narrow band, leave outside the wide one
      if (diff <= CW'(LOCK_TOL)) lock_d = 1'b1;
      else if (diff > CW'(UNLOCK_TOL)) lock_d = 1'b0;
      if (diff <= CW'(TRACK_TOL)) track_d = 1'b1;
      else if (diff > CW'(UNTRACK_TOL)) track_d = 1'b0;
    end else begin
      win_d = win_q + CW'(xtal_edge);
      if (vcnt_q != {CW{1'b1}}) vcnt_d = vcnt_now;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      win_q <= '0;
      vcnt_q <= '0;
      lock_q <= 1'b0;
      track_q <= 1'b0;
    end else begin
      win_q <= win_d;
      vcnt_q <= vcnt_d;
      lock_q <= lock_d;
      track_q <= track_d;
    end
  end

  assign lock = lock_q;
  assign track = track_q;

endmodule : pcg_lock_det
`default_nettype wire

/* sim/pcg_clock_gen_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_gen_assertions (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire pcg_pkg::pcg_bus_req_t bus_req, // register request
  input wire logic [7:0] rdata, // read data
  input wire logic osc_enable_in, // osc enable
  input wire logic base_clock_out, // base clock
  input wire logic lock_change_irq, // irq
  input wire logic osc_run_en, // osc run
  input wire logic pll_run_en, // pll run
  input wire logic loop_track_mode, // filter mode
  input wire logic [3:0] vco_mult, // multiplier
  input wire logic [3:0] vco_range // range
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic auto_q, trk_q;
  wire bw_wr = bus_req.wr && bus_req.addr == pcg_pkg::ADDR_BW;
  // manual tracking value is only taken while the old mode was manual
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auto_q <= 1'b0;
      trk_q <= 1'b0;
    end else if (bw_wr) begin
      auto_q <= bus_req.wdata[pcg_pkg::BW_AUTO_BIT];
      trk_q <= auto_q ? trk_q : bus_req.wdata[pcg_pkg::BW_TRK_BIT];
    end
  end
  ////////////////////////////////////////////////////////////
  property p_ctrl_low;
    bus_req.rd && bus_req.addr == pcg_pkg::ADDR_CTRL |=> rdata[3:0] == pcg_pkg::CTRL_LOW_READ;
  endproperty
  a_ctrl_low: assert property (p_ctrl_low) else $error("ctrl low bits");
  property p_bw_manual;
    bus_req.rd && bus_req.addr == pcg_pkg::ADDR_BW && !auto_q |=> !rdata[pcg_pkg::BW_LOCK_BIT];
  endproperty
  a_bw_manual: assert property (p_bw_manual) else $error("lock seen in manual");
  property p_irq_manual;
    (!auto_q)[*3] |-> !lock_change_irq;
  endproperty
  a_irq_manual: assert property (p_irq_manual) else $error("irq in manual");
  property p_track_manual;
    (!auto_q && $stable(trk_q))[*3] |-> loop_track_mode == trk_q;
  endproperty
  a_track_manual: assert property (p_track_manual) else $error("manual tracking");
  property p_mult_nz;
    $past(rst_n) |-> vco_mult != pcg_pkg::FIELD_ZERO;
  endproperty
  a_mult_nz: assert property (p_mult_nz) else $error("multiplier zero");
  property p_range_off;
    (vco_range == pcg_pkg::FIELD_ZERO)[*2] |-> !pll_run_en;
  endproperty
  a_range_off: assert property (p_range_off) else $error("pll on at range zero");
  property p_osc_drop;
    $fell(osc_enable_in) |-> ##[1:8] (!osc_run_en && !pll_run_en);
  endproperty
  a_osc_drop: assert property (p_osc_drop) else $error("osc drop ignored");
  property p_osc_gate;
    (!osc_run_en)[*3] |-> !pll_run_en;
  endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("pll without osc");
  property p_base_pace;
    $changed(base_clock_out) |=> $stable(base_clock_out);
  endproperty
  a_base_pace: assert property (p_base_pace) else $error("base clock too fast");
  property p_prog_ro;
    pll_run_en && bus_req.wr && bus_req.addr == pcg_pkg::ADDR_PROG |=> $stable(vco_range)[*2];
  endproperty
  a_prog_ro: assert property (p_prog_ro) else $error("program changed while on");
  c_irq: cover property (lock_change_irq);
  c_vco: cover property (pll_run_en && $changed(base_clock_out));
  c_one: cover property (vco_mult == pcg_pkg::FIELD_ONE);
endmodule : pcg_clock_gen_assertions
`default_nettype wire

/* sim/pcg_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcg_src_model #(
  parameter realtime XHALF = 96.0
) (
  input wire logic osc_enable_in, // gates the crystal
  input wire logic pll_run_en, // vco runs only while set
  input wire logic [3:0] vco_mult, // feedback multiplier
  output logic crystal_clock, // reference
  output logic vco_clock // vco output
);
  // stopped clocks rest low, as a gated oscillator would
  initial begin
    crystal_clock = 1'b0;
    forever begin
      #(XHALF);
      crystal_clock = osc_enable_in ? ~crystal_clock : 1'b0;
    end
  end
  // wait out the unknown multiplier before reset lands, and keep vco edges
  // off the clk edges so the synchroniser never races the model
  initial begin
    vco_clock = 1'b0;
    #11;
    forever begin
      #(XHALF / ((vco_mult == 4'h0) ? 1 : vco_mult));
      vco_clock = pll_run_en ? ~vco_clock : 1'b0;
    end
  end
endmodule : pcg_src_model
`default_nettype wire

/* sim/tb_pcg_clock_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pcg_clock_gen;
  logic clk = 1'b0, rst_n = 1'b0, osc_enable_in = 1'b1, rd_d = 1'b0;
  pcg_pkg::pcg_bus_req_t bus_req = '0;
  logic crystal_clock, vco_clock, base_clock_out, lock_change_irq, osc_run_en, pll_run_en;
  logic loop_track_mode;
  logic [3:0] vco_mult, vco_range;
  logic [7:0] rdata, m, v, exp_q[$], msk_q[$];
  int fails = 0, n_compared = 0, i;
  time t0;
  always #2 clk = ~clk;
  pcg_clock_gen dut (.clk, .rst_n, .bus_req, .rdata, .crystal_clock, .vco_clock, .osc_enable_in,
    .base_clock_out, .lock_change_irq, .osc_run_en, .pll_run_en, .loop_track_mode, .vco_mult,
    .vco_range);
  pcg_src_model model (.osc_enable_in, .pll_run_en, .vco_mult, .crystal_clock, .vco_clock);
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] mk = 8'hff);
    @(posedge clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    exp_q.push_back(e);
    msk_q.push_back(mk);
    @(posedge clk);
    bus_req <= '0;
  endtask : rd
  task automatic gap(input int lo, input int hi);
    @(base_clock_out);
    t0 = $time;
    @(base_clock_out);
    chk(8'(($time - t0) / 4 inside {[lo:hi]}), 8'h01);
  endtask : gap
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= bus_req.rd;
    if (rd_d) begin
      m = msk_q.pop_front();
      chk(rdata & m, exp_q.pop_front() & m);
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  initial begin
    void'($urandom(89618));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(2'h0, 8'h2f);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h66);
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    wr(2'h2, 8'h12);
    rd(2'h2, 8'h66);
    wr(2'h0, 8'h30);
    rd(2'h0, 8'h3f);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h2f);
    wr(2'h0, 8'h00);
    wr(2'h0, 8'h30);
    rd(2'h0, 8'h2f);
    wr(2'h0, 8'h00);
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h05 : 8'($urandom);
      if (v[3:0] == 4'h0) v[3:0] = 4'h1;
      wr(2'h2, v);
      rd(2'h2, v);
      repeat (3) @(posedge clk);
      chk({4'h0, vco_mult}, (v[7:4] == 4'h0) ? 8'h01 : {4'h0, v[7:4]});
      chk({4'h0, vco_range}, {4'h0, v[3:0]});
    end
    wr(2'h2, 8'h60);
    wr(2'h0, 8'h20);
    wr(2'h0, 8'h30);
    rd(2'h0, 8'h2f);
    chk({7'h0, pll_run_en}, 8'h00);
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h20);
    rd(2'h1, 8'h20);
    chk({7'h0, loop_track_mode}, 8'h01);
    wr(2'h1, 8'h00);
    rd(2'h1, 8'h00);
    wr(2'h2, 8'h66);
    wr(2'h1, 8'h80);
    wr(2'h0, 8'ha0);
    for (i = 0; i < 8000 && lock_change_irq !== 1'b1; i++) @(posedge clk);
    chk({7'h0, lock_change_irq}, 8'h01);
    rd(2'h1, 8'he0, 8'he0);
    rd(2'h0, 8'hef);
    rd(2'h0, 8'haf);
    repeat (2) @(posedge clk);
    chk({7'h0, lock_change_irq}, 8'h00);
    wr(2'h1, 8'h80);
    rd(2'h1, 8'h20, 8'h20);
    gap(47, 49);
    wr(2'h0, 8'hb0);
    repeat (2) @(posedge clk);
    v = {7'h0, base_clock_out};
    repeat (80) @(posedge clk) chk({7'h0, base_clock_out}, v);
    repeat (200) @(posedge clk);
    gap(7, 9);
    wr(2'h0, 8'h90);
    rd(2'h0, 8'h3f, 8'h3f);
    wr(2'h0, 8'h80);
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h00);
    wr(2'h0, 8'h20);
    repeat (60) @(posedge clk);
    wr(2'h1, 8'h20);
    repeat (60) @(posedge clk);
    wr(2'h0, 8'h30);
    rd(2'h0, 8'h3f);
    chk({7'h0, lock_change_irq}, 8'h00);
    osc_enable_in <= 1'b0;
    repeat (10) @(posedge clk);
    chk({6'h0, osc_run_en, pll_run_en}, 8'h00);
    report_and_stop();
  end
endmodule : tb_pcg_clock_gen
bind pcg_clock_gen pcg_clock_gen_assertions u_sva (.clk, .rst_n, .bus_req, .rdata, .osc_enable_in,
  .base_clock_out, .lock_change_irq, .osc_run_en, .pll_run_en, .loop_track_mode, .vco_mult,
  .vco_range);
`default_nettype wire
